/* exec_regs.vh */
// constants for the instruction execute unit
`ifndef EXEC_REGS_VH
`define EXEC_REGS_VH
// operation codes on op_code
`define OP_NOP      5'h00
`define OP_OR_AM    5'h01
`define OP_OR_MA    5'h02
`define OP_OR_AI    5'h03
`define OP_XOR_AM   5'h04
`define OP_XOR_MA   5'h05
`define OP_XOR_AI   5'h06
`define OP_SWAP     5'h07
`define OP_SWAPM    5'h08
`define OP_RRC      5'h09
`define OP_RRCM     5'h0a
`define OP_RLC      5'h0b
`define OP_RLCM     5'h0c
`define OP_BCLR     5'h0d
`define OP_BSET     5'h0e
`define OP_CMP_AI   5'h0f
`define OP_CMP_AM   5'h10
`define OP_INCS     5'h11
`define OP_INCMS    5'h12
`define OP_DECS     5'h13
`define OP_DECMS    5'h14
`define OP_BTS0     5'h15
`define OP_BTS1     5'h16
`define OP_JMP      5'h17
`define OP_CALL     5'h18
`define OP_RET      5'h19
`define OP_RETI     5'h1a
`define OP_PUSH     5'h1b
`define OP_POP      5'h1c
// flag register bit positions
`define FLG_CARRY   0
`define FLG_HALF    1
`define FLG_ZERO    2
`define FLG_PD      6
`define FLG_TO      7
// flag bits kept out of push and pop
`define FLG_KEEP    8'hc0
// reset values
`define WORK_RST    8'h00
`define FLAG_RST    8'h00
`define PC_RST      16'h0000
// minimum external interrupt pulse in cpu cycles
`define INT_MIN_CYC 2
`define STACK_DEPTH 8
`endif

/* sync_pulse.v */
// three-flop synchroniser with agreement qualifier
`default_nettype none
module sync_pulse (
    input  wire mclk,
    input  wire srst,
    input  wire din,
    output reg  dout_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge mclk) begin
        if (srst) begin
            // pin idles high; reset there so no false edge follows
            s1_q   <= 1'b1;
            s2_q   <= 1'b1;
            s3_q   <= 1'b1;
            dout_q <= 1'b1;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // change counts only once stages two and three agree
            if (s2_q == s3_q) begin
                dout_q <= s3_q;
            end
        end
    end
endmodule
`default_nettype wire

/* cpu_instruction_execute.v */
// execute unit for logic, rotate, bit, skip, branch and save ops
`include "exec_regs.vh"
`default_nettype none
// Function
// RULE1: or/xor to memory, zero flag, 1+N
// RULE2: or/xor immediate to work register, one cycle
// RULE3: swap nibbles into work register, no flags
// RULE4: swap nibbles in memory, 1+N
// RULE5: rotate through carry, carry only
// RULE6: bit clear/set, no flags, 1+N
// RULE7: compare immediate, set flags, skip equal
// RULE8: compare memory, set flags, skip equal
// RULE9: increment, skip on zero, no flags
// RULE10: decrement, skip on zero, no flags
// RULE11: bit test skip on chosen polarity
// RULE12: jump loads page bits and operand
// RULE13: call pushes pc, then jumps
// RULE14: reti restores pc, enables interrupts
// RULE15: push saves work and flags, one cycle
// RULE16: pop restores, keeps timeout/power-down
// RULE17: N is 0 for system register
// RULE18: S is 1 when skip taken
// RULE19: external interrupt held two cycles
// RULE20: skipped instruction changes nothing
// RULE21: nop changes nothing, one cycle
module cpu_instruction_execute (
    input  wire        mclk,
    input  wire        srst,
    input  wire        op_valid,
    input  wire [4:0]  op_code,
    input  wire [7:0]  mem_rdata,
    input  wire        mem_is_sysreg,
    input  wire [7:0]  imm_data,
    input  wire [2:0]  bit_sel,
    input  wire [13:0] jump_addr,
    input  wire [1:0]  rom_page_select,
    input  wire        external_interrupt_line,
    output reg         op_ready_q,
    output reg         mem_we_q,
    output reg  [7:0]  mem_wdata_q,
    output reg  [7:0]  work_register_q,
    output reg  [7:0]  program_flag_register_q,
    output reg  [15:0] pc_q,
    output reg         global_int_en_q,
    output reg         ext_int_req_q
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_EXTRA = 3'b010;
    localparam ST_SKIP  = 3'b100;

    reg [2:0]  state_q;
    reg [1:0]  wait_q;
    reg        skip_pend_q;
    reg [7:0]  save_work_q;
    reg [7:0]  save_flag_q;
    reg [15:0] stack_q [0:`STACK_DEPTH-1];
    reg [2:0]  sp_q;
    reg        int_prev_q;
    wire       int_sync;

    // rule19 relies on pulses long enough to survive the filter
    sync_pulse u_sync (
        .mclk   (mclk),
        .srst   (srst),
        .din    (external_interrupt_line),
        .dout_q (int_sync)
    );

    function [7:0] swap_nib;
        input [7:0] v;
        begin
            swap_nib = {v[3:0], v[7:4]};
        end
    endfunction

    function [7:0] bit_mask;
        input [2:0] b;
        begin
            bit_mask = 8'h01 << b;
        end
    endfunction

    // or when sel_or is set, xor otherwise
    function [7:0] or_xor;
        input       sel_or;
        input [7:0] a;
        input [7:0] b;
        begin
            or_xor = sel_or ? (a | b) : (a ^ b);
        end
    endfunction

    function ret_op;
        input [4:0] c;
        begin
            ret_op = (c == `OP_RET) | (c == `OP_RETI);
        end
    endfunction

    reg [7:0] res;
    reg       wr_mem;
    reg       wr_work;
    reg [7:0] flag_n;
    reg       skip;
    reg [1:0] cost;
    reg [8:0] diff;
    reg       mem_op;

    // decode once; results land on the edge that takes the op
    always @* begin
        res     = 8'h00;
        wr_mem  = 1'b0;
        wr_work = 1'b0;
        flag_n  = program_flag_register_q;
        skip    = 1'b0;
        mem_op  = 1'b0;
        // shared subtractor, compare immediate replaces the operand
        diff    = {1'b0, work_register_q} - {1'b0, mem_rdata};
        case (op_code)
            `OP_OR_AM, `OP_XOR_AM: begin
                res = or_xor(op_code == `OP_OR_AM, work_register_q, mem_rdata);
                wr_work = 1'b1;
                flag_n[`FLG_ZERO] = (res == 8'h00);
            end
            // RULE1 memory write, zero only
            `OP_OR_MA, `OP_XOR_MA: begin
                res = or_xor(op_code == `OP_OR_MA, work_register_q, mem_rdata);
                wr_mem = 1'b1;
                flag_n[`FLG_ZERO] = (res == 8'h00);
            end
            // RULE2 immediate into work
            `OP_OR_AI, `OP_XOR_AI: begin
                res = or_xor(op_code == `OP_OR_AI, work_register_q, imm_data);
                wr_work = 1'b1;
                flag_n[`FLG_ZERO] = (res == 8'h00);
            end
            // RULE3 swap into work
            `OP_SWAP: begin
                res = swap_nib(mem_rdata);
                wr_work = 1'b1;
            end
            // RULE4 swap in place
            `OP_SWAPM: begin
                res = swap_nib(mem_rdata);
                wr_mem = 1'b1;
            end
            // RULE5 rotate right through carry
            `OP_RRC, `OP_RRCM: begin
                res = {program_flag_register_q[`FLG_CARRY], mem_rdata[7:1]};
                flag_n[`FLG_CARRY] = mem_rdata[0];
                wr_work = (op_code == `OP_RRC);
                wr_mem  = (op_code == `OP_RRCM);
            end
            // RULE5 rotate left through carry
            `OP_RLC, `OP_RLCM: begin
                res = {mem_rdata[6:0], program_flag_register_q[`FLG_CARRY]};
                flag_n[`FLG_CARRY] = mem_rdata[7];
                wr_work = (op_code == `OP_RLC);
                wr_mem  = (op_code == `OP_RLCM);
            end
            // RULE6 bit force, flags untouched
            `OP_BCLR: begin
                res = mem_rdata & ~bit_mask(bit_sel);
                wr_mem = 1'b1;
            end
            `OP_BSET: begin
                res = mem_rdata | bit_mask(bit_sel);
                wr_mem = 1'b1;
            end
            // RULE7 compare immediate, carry means no borrow
            `OP_CMP_AI: begin
                diff = {1'b0, work_register_q} - {1'b0, imm_data};
                flag_n[`FLG_CARRY] = ~diff[8];
                flag_n[`FLG_ZERO]  = (diff[7:0] == 8'h00);
                skip = (diff[7:0] == 8'h00);
            end
            // RULE8 compare memory, difference dropped
            `OP_CMP_AM: begin
                flag_n[`FLG_CARRY] = ~diff[8];
                flag_n[`FLG_ZERO]  = (diff[7:0] == 8'h00);
                skip = (diff[7:0] == 8'h00);
            end
            // RULE9 increment and skip on zero
            `OP_INCS, `OP_INCMS: begin
                res = mem_rdata + 8'h01;
                skip = (res == 8'h00);
                wr_work = (op_code == `OP_INCS);
                wr_mem  = (op_code == `OP_INCMS);
            end
            // RULE10 decrement and skip on zero
            `OP_DECS, `OP_DECMS: begin
                res = mem_rdata - 8'h01;
                skip = (res == 8'h00);
                wr_work = (op_code == `OP_DECS);
                wr_mem  = (op_code == `OP_DECMS);
            end
            // RULE11 bit test polarity
            `OP_BTS0: begin
                skip = ~mem_rdata[bit_sel];
            end
            `OP_BTS1: begin
                skip = mem_rdata[bit_sel];
            end
            // RULE16 pop keeps timeout and power-down bits
            `OP_POP: begin
                res = save_work_q;
                wr_work = 1'b1;
                flag_n = (save_flag_q & ~`FLG_KEEP) |
                         (program_flag_register_q & `FLG_KEEP);
            end
            default: begin
                res = 8'h00;
            end
        endcase
        mem_op = wr_mem;
        // RULE17 write-back cycle only for data ram
        // RULE18 skip cycle only when taken
        cost = {1'b0, mem_op & ~mem_is_sysreg} + {1'b0, skip};
    end

    wire is_branch = (op_code == `OP_JMP) | (op_code == `OP_CALL) |
                     ret_op(op_code);
    wire [2:0] sp_dec = sp_q - 3'd1;

    // stack cleared on reset so a stray return is defined
    integer i;
    always @(posedge mclk) begin
        if (srst) begin
            state_q                 <= ST_IDLE;
            wait_q                  <= 2'd0;
            skip_pend_q             <= 1'b0;
            save_work_q             <= `WORK_RST;
            save_flag_q             <= `FLAG_RST;
            sp_q                    <= 3'd0;
            op_ready_q              <= 1'b1;
            mem_we_q                <= 1'b0;
            mem_wdata_q             <= 8'h00;
            work_register_q         <= `WORK_RST;
            program_flag_register_q <= `FLAG_RST;
            pc_q                    <= `PC_RST;
            global_int_en_q         <= 1'b0;
            ext_int_req_q           <= 1'b0;
            // pin idles high, so reset leaves no edge behind
            int_prev_q              <= 1'b1;
            for (i = 0; i < `STACK_DEPTH; i = i + 1) begin
                stack_q[i] <= `PC_RST;
            end
        end else begin
            // write strobe stands for one cycle only
            mem_we_q   <= 1'b0;
            int_prev_q <= int_sync;
            // falling edge request, held until the next reset
            if (int_prev_q & ~int_sync) begin
                ext_int_req_q <= 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    // requests while busy are simply not taken
                    if (op_valid) begin
                        // RULE21 nop touches nothing
                        if (op_code == `OP_NOP) begin
                            pc_q <= pc_q + 16'h0001;
                        end else if (is_branch) begin
                            op_ready_q <= 1'b0;
                            wait_q     <= 2'd1;
                            state_q    <= ST_EXTRA;
                            if (ret_op(op_code)) begin
                                // RULE14 counter from stack
                                pc_q <= stack_q[sp_dec];
                                sp_q <= sp_dec;
                                if (op_code == `OP_RETI) begin
                                    global_int_en_q <= 1'b1;
                                end
                            end else begin
                                // RULE13 push return address
                                if (op_code == `OP_CALL) begin
                                    // eight deep; a ninth call overwrites
                                    stack_q[sp_q] <= pc_q + 16'h0001;
                                    sp_q <= sp_q + 3'd1;
                                end
                                // RULE12 page bits above operand
                                pc_q <= {rom_page_select, jump_addr};
                            end
                        end else begin
                            pc_q <= pc_q + 16'h0001;
                            if (op_code == `OP_PUSH) begin
                                // RULE15 shadow copy, status bits excluded
                                save_work_q <= work_register_q;
                                save_flag_q <= program_flag_register_q &
                                               ~`FLG_KEEP;
                            end
                            if (wr_work) begin
                                work_register_q <= res;
                            end
                            program_flag_register_q <= flag_n;
                            if (wr_mem) begin
                                mem_we_q    <= 1'b1;
                                mem_wdata_q <= res;
                            end
                            if (cost != 2'd0) begin
                                op_ready_q  <= 1'b0;
                                wait_q      <= cost;
                                skip_pend_q <= skip;
                                // a skip-only op owes just the skip cycle
                                if (cost == {1'b0, skip}) begin
                                    state_q <= ST_SKIP;
                                end else begin
                                    state_q <= ST_EXTRA;
                                end
                            end
                        end
                    end
                end
                // write-back or branch refill cycle
                ST_EXTRA: begin
                    if (skip_pend_q) begin
                        // skip cycle follows the write-back, not on top
                        state_q <= ST_SKIP;
                    end else if (wait_q == 2'd1) begin
                        op_ready_q <= 1'b1;
                        state_q    <= ST_IDLE;
                    end else begin
                        wait_q <= wait_q - 2'd1;
                    end
                end
                // RULE20 skipped word fetched, only pc moves
                ST_SKIP: begin
                    pc_q        <= pc_q + 16'h0001;
                    skip_pend_q <= 1'b0;
                    op_ready_q  <= 1'b1;
                    state_q     <= ST_IDLE;
                end
                default: begin
                    state_q    <= ST_IDLE;
                    op_ready_q <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* cpu_instruction_execute_chk.sv */
// assertion checker watching the execute unit ports
`default_nettype none
`include "exec_regs.vh"
module cpu_instruction_execute_chk (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        op_valid,
    input wire logic [4:0]  op_code,
    input wire logic [7:0]  mem_rdata,
    input wire logic        mem_is_sysreg,
    input wire logic [7:0]  imm_data,
    input wire logic [2:0]  bit_sel,
    input wire logic [13:0] jump_addr,
    input wire logic [1:0]  rom_page_select,
    input wire logic        external_interrupt_line,
    input wire logic        op_ready_q,
    input wire logic        mem_we_q,
    input wire logic [7:0]  mem_wdata_q,
    input wire logic [7:0]  work_register_q,
    input wire logic [7:0]  program_flag_register_q,
    input wire logic [15:0] pc_q,
    input wire logic        global_int_en_q,
    input wire logic        ext_int_req_q
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic       take;
    logic      [7:0] rd_q;
    logic      [7:0] fl_q;
    assign take = op_valid & op_ready_q;
    // operand copies, so slices can be compared a cycle later
    always_ff @(posedge mclk) begin
        rd_q <= mem_rdata;
        fl_q <= program_flag_register_q;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    a_or_mem_write: assert property (
        take && op_code == `OP_OR_MA && !mem_is_sysreg |=> (mem_we_q
        && mem_wdata_q == ($past(work_register_q) | $past(mem_rdata))
        && !op_ready_q) ##1 (op_ready_q && !mem_we_q))
        else $error("or to memory result or timing wrong");
    a_sysreg_no_stall: assert property (
        take && mem_is_sysreg && (op_code == `OP_SWAPM || op_code == `OP_BCLR)
        |=> mem_we_q && op_ready_q)
        else $error("system register write stalled");
    a_swap_work: assert property (
        take && op_code == `OP_SWAP |=> work_register_q
        == {rd_q[3:0], rd_q[7:4]} && $stable(program_flag_register_q))
        else $error("nibble swap to work register wrong");
    a_rotate_carry: assert property (
        take && op_code == `OP_RRC |=> work_register_q
        == {fl_q[0], rd_q[7:1]} && program_flag_register_q[0] == rd_q[0])
        else $error("rotate right through carry wrong");
    a_bit_set: assert property (
        take && op_code == `OP_BSET |=> mem_we_q
        && mem_wdata_q == (rd_q | (8'h01 << $past(bit_sel))))
        else $error("bit set result wrong");
    a_cmp_skip: assert property (
        take && op_code == `OP_CMP_AI && work_register_q == imm_data
        |=> (!op_ready_q && program_flag_register_q[`FLG_ZERO])
        ##1 op_ready_q)
        else $error("equal compare did not skip once");
    a_jump_pc: assert property (
        take && op_code == `OP_JMP |=> (pc_q == {$past(rom_page_select),
        $past(jump_addr)} && !op_ready_q) ##1 op_ready_q)
        else $error("jump target or cost wrong");
    a_reti_gie: assert property (
        take && op_code == `OP_RETI |=> global_int_en_q && !op_ready_q)
        else $error("return from interrupt left interrupts off");
    a_pop_keep: assert property (
        take && op_code == `OP_POP |=> (program_flag_register_q
        & `FLG_KEEP) == (fl_q & `FLG_KEEP) && op_ready_q)
        else $error("restore touched timeout or power-down bits");
    a_nop_idle: assert property (
        take && op_code == `OP_NOP |=> op_ready_q && !mem_we_q
        && $stable(work_register_q) && $stable(program_flag_register_q))
        else $error("no-operation changed state");
endmodule
bind cpu_instruction_execute cpu_instruction_execute_chk
    cpu_instruction_execute_chk_i (
    .mclk(mclk), .srst(srst), .op_valid(op_valid), .op_code(op_code),
    .mem_rdata(mem_rdata), .mem_is_sysreg(mem_is_sysreg),
    .imm_data(imm_data), .bit_sel(bit_sel), .jump_addr(jump_addr),
    .rom_page_select(rom_page_select),
    .external_interrupt_line(external_interrupt_line),
    .op_ready_q(op_ready_q), .mem_we_q(mem_we_q),
    .mem_wdata_q(mem_wdata_q), .work_register_q(work_register_q),
    .program_flag_register_q(program_flag_register_q), .pc_q(pc_q),
    .global_int_en_q(global_int_en_q), .ext_int_req_q(ext_int_req_q));
`default_nettype wire

/* cpu_instruction_execute_tb.sv */
// self-checking bench for the execute unit
`default_nettype none
`include "exec_regs.vh"
module cpu_instruction_execute_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        op_valid = 1'b0;
    logic [4:0]  op_code = 5'h00;
    logic [7:0]  mem_rdata = 8'h00;
    logic        mem_is_sysreg = 1'b0;
    logic [7:0]  imm_data = 8'h00;
    logic [2:0]  bit_sel = 3'h0;
    logic [13:0] jump_addr = 14'h0000;
    logic [1:0]  rom_page_select = 2'h0;
    logic        external_interrupt_line = 1'b1;
    wire logic        op_ready_q;
    wire logic        mem_we_q;
    wire logic [7:0]  mem_wdata_q;
    wire logic [7:0]  work_register_q;
    wire logic [7:0]  program_flag_register_q;
    wire logic [15:0] pc_q;
    wire logic        global_int_en_q;
    wire logic        ext_int_req_q;
    int               n_fail = 0;
    int               checked = 0;
    logic             we;
    logic [7:0]       wd;
    logic [15:0]      p0;
    cpu_instruction_execute cpu_instruction_execute_i (
        .mclk(mclk), .srst(srst), .op_valid(op_valid), .op_code(op_code),
        .mem_rdata(mem_rdata), .mem_is_sysreg(mem_is_sysreg),
        .imm_data(imm_data), .bit_sel(bit_sel), .jump_addr(jump_addr),
        .rom_page_select(rom_page_select),
        .external_interrupt_line(external_interrupt_line),
        .op_ready_q(op_ready_q), .mem_we_q(mem_we_q),
        .mem_wdata_q(mem_wdata_q), .work_register_q(work_register_q),
        .program_flag_register_q(program_flag_register_q), .pc_q(pc_q),
        .global_int_en_q(global_int_en_q), .ext_int_req_q(ext_int_req_q));
    always #20 mclk = ~mclk;
    task automatic chk(input string nm, input logic [16:0] s,
                       input logic [16:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one operation; counts stall cycles until ready returns
    task automatic op(input logic [4:0] c, input logic [7:0] m,
                      input logic s, input logic [7:0] i,
                      input logic [2:0] b, input int es);
        int n;
        n = 0;
        @(posedge mclk);
        op_code <= c;
        mem_rdata <= m;
        mem_is_sysreg <= s;
        imm_data <= i;
        bit_sel <= b;
        op_valid <= 1'b1;
        @(posedge mclk);
        op_valid <= 1'b0;
        #1;
        we = mem_we_q;
        wd = mem_wdata_q;
        while (op_ready_q !== 1'b1 && n < 8) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("stall cycles", 16'(n), 16'(es));
    endtask
    task automatic t_logic;
        op(`OP_SWAP, 8'h5a, 1'b0, 8'h00, 3'h0, 0);
        chk("swap work", work_register_q, 8'ha5);
        chk("swap flags", program_flag_register_q, 8'h00);
        op(`OP_OR_AI, 8'h00, 1'b0, 8'h0f, 3'h0, 0);
        chk("or imm work", work_register_q, 8'haf);
        op(`OP_XOR_AI, 8'h00, 1'b0, 8'haf, 3'h0, 0);
        chk("xor imm work", work_register_q, 8'h00);
        chk("xor imm flags", program_flag_register_q, 8'h04);
        op(`OP_OR_MA, 8'h30, 1'b0, 8'h00, 3'h0, 1);
        chk("or mem data", {we, wd}, 9'h130);
        chk("or mem flags", program_flag_register_q, 8'h00);
        op(`OP_XOR_MA, 8'h00, 1'b1, 8'h00, 3'h0, 0);
        chk("xor sysreg flags", program_flag_register_q, 8'h04);
        op(`OP_SWAPM, 8'h12, 1'b0, 8'h00, 3'h0, 1);
        chk("swapm data", {we, wd}, 9'h121);
        $display("test logic done");
    endtask
    task automatic t_rotate;
        op(`OP_CMP_AI, 8'h00, 1'b0, 8'h01, 3'h0, 0);
        chk("cmp borrow flags", program_flag_register_q, 8'h00);
        op(`OP_RRC, 8'h03, 1'b0, 8'h00, 3'h0, 0);
        chk("rrc work", work_register_q, 8'h01);
        chk("rrc flags", program_flag_register_q, 8'h01);
        op(`OP_RLCM, 8'h80, 1'b0, 8'h00, 3'h0, 1);
        chk("rlcm data", {we, wd}, 9'h101);
        chk("rlcm flags", program_flag_register_q, 8'h01);
        $display("test rotate done");
    endtask
    task automatic t_bits;
        op(`OP_BSET, 8'h00, 1'b0, 8'h00, 3'h7, 1);
        chk("bset data", {we, wd}, 9'h180);
        op(`OP_BCLR, 8'hff, 1'b1, 8'h00, 3'h0, 0);
        chk("bclr data", {we, wd}, 9'h1fe);
        p0 = pc_q;
        op(`OP_BTS0, 8'hf7, 1'b0, 8'h00, 3'h3, 1);
        chk("bts0 pc", pc_q, p0 + 16'h0002);
        op(`OP_BTS1, 8'hf7, 1'b0, 8'h00, 3'h3, 0);
        chk("bts flags", program_flag_register_q, 8'h01);
        $display("test bits done");
    endtask
    task automatic t_skip;
        op(`OP_CMP_AM, 8'h01, 1'b0, 8'h00, 3'h0, 1);
        chk("cmp mem flags", program_flag_register_q, 8'h05);
        p0 = pc_q;
        op(`OP_INCMS, 8'hff, 1'b0, 8'h00, 3'h0, 2);
        chk("incms data", {we, wd}, 9'h100);
        chk("incms pc", pc_q, p0 + 16'h0002);
        chk("skip work kept", work_register_q, 8'h01);
        op(`OP_INCS, 8'h41, 1'b0, 8'h00, 3'h0, 0);
        chk("incs work", work_register_q, 8'h42);
        op(`OP_DECS, 8'h01, 1'b0, 8'h00, 3'h0, 1);
        chk("decs work", work_register_q, 8'h00);
        chk("decs flags", program_flag_register_q, 8'h05);
        op(`OP_DECMS, 8'h05, 1'b1, 8'h00, 3'h0, 0);
        chk("decms data", {we, wd}, 9'h104);
        $display("test skip done");
    endtask
    task automatic t_branch;
        @(posedge mclk);
        jump_addr <= 14'h1234;
        rom_page_select <= 2'h2;
        op(`OP_JMP, 8'h00, 1'b0, 8'h00, 3'h0, 1);
        chk("jump pc", pc_q, 16'h9234);
        @(posedge mclk);
        jump_addr <= 14'h0100;
        rom_page_select <= 2'h1;
        op(`OP_CALL, 8'h00, 1'b0, 8'h00, 3'h0, 1);
        chk("call pc", pc_q, 16'h4100);
        op(`OP_RET, 8'h00, 1'b0, 8'h00, 3'h0, 1);
        chk("ret pc and gie", {pc_q, global_int_en_q}, 17'h1_246a);
        op(`OP_CALL, 8'h00, 1'b0, 8'h00, 3'h0, 1);
        op(`OP_RETI, 8'h00, 1'b0, 8'h00, 3'h0, 1);
        chk("reti pc and gie", {pc_q, global_int_en_q}, 17'h1_246d);
        op(`OP_NOP, 8'h00, 1'b0, 8'h00, 3'h0, 0);
        chk("nop pc", pc_q, 16'h9237);
        chk("nop work", work_register_q, 8'h00);
        $display("test branch done");
    endtask
    task automatic t_stash;
        op(`OP_CMP_AI, 8'h00, 1'b0, 8'h00, 3'h0, 1);
        op(`OP_PUSH, 8'h00, 1'b0, 8'h00, 3'h0, 0);
        op(`OP_SWAP, 8'h3c, 1'b0, 8'h00, 3'h0, 0);
        op(`OP_CMP_AI, 8'h00, 1'b0, 8'hff, 3'h0, 0);
        chk("scratch flags", program_flag_register_q, 8'h00);
        op(`OP_POP, 8'h00, 1'b0, 8'h00, 3'h0, 0);
        chk("pop work", work_register_q, 8'h00);
        chk("pop flags", program_flag_register_q, 8'h05);
        $display("test stash done");
    endtask
    // two-cycle low pulse, the shortest a source may give
    task automatic t_int;
        #1;
        chk("int idle", ext_int_req_q, 1'b0);
        @(posedge mclk);
        external_interrupt_line <= 1'b0;
        repeat (2) @(posedge mclk);
        external_interrupt_line <= 1'b1;
        repeat (6) @(posedge mclk);
        #1;
        chk("int request", ext_int_req_q, 1'b1);
        $display("test interrupt done");
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        t_int();
        t_logic();
        t_rotate();
        t_bits();
        t_skip();
        t_branch();
        t_stash();
        conclude();
    end
    // about 90 cycles expected; far longer means a hang
    initial begin
        #50000;
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
